// ===== design/uxf_defines.vh
/*
 * Constants of the receive-command and transmit framing block: status byte
 * fields, codes, APB offsets and framing lengths.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef UXF_DEFINES_VH
`define UXF_DEFINES_VH

// Status byte layout.
`define UXF_LS_LO        0
`define UXF_LS_HI        1
`define UXF_VB_LO        2
`define UXF_VB_HI        3
`define UXF_EV_LO        4
`define UXF_EV_HI        5
`define UXF_ID_BIT       6
`define UXF_ALT_BIT      7

// Vbus codes.
`define UXF_VB_SESS_END  2'h0
`define UXF_VB_BELOW_SV  2'h1
`define UXF_VB_BELOW_VV  2'h2
`define UXF_VB_ABOVE_VV  2'h3

// Receive event codes.
`define UXF_EV_IDLE      2'h0
`define UXF_EV_ACTIVE    2'h1
`define UXF_EV_ERROR     2'h3
`define UXF_EV_HOST_DISCONNECT_SEEN   2'h2

// Speed select and operating mode codes.
`define UXF_SPD_HS       2'h0
`define UXF_OPM_NORMAL   2'h0
`define UXF_OPM_CHIRP    2'h2

// Start-of-frame PID low nibble and full PID.
`define UXF_PID_SOF      4'h5
`define UXF_PID_SOF_FULL 8'hA5

// Framing lengths in line bits.
`define UXF_SYNC_HS      6'h20
`define UXF_SYNC_FSLS    6'h08
`define UXF_EOP_LONG     6'h28
`define UXF_EOP_HS       6'h08
`define UXF_EOP_FSLS     6'h03

// APB register offsets.
`define UXF_A_CTRL       12'h000
`define UXF_A_STATUS     12'h004
`define UXF_A_IRQ_STAT   12'h008
`define UXF_A_IRQ_MASK   12'h00C
`define UXF_A_TX         12'h010
`define UXF_A_ALT        12'h014

// Control register fields.
`define UXF_C_SPD_LO     0
`define UXF_C_SPD_HI     1
`define UXF_C_TERM       2
`define UXF_C_OPM_LO     3
`define UXF_C_OPM_HI     4
`define UXF_C_DPPD       5
`define UXF_C_DMPD       6

// Interrupt status bits.
`define UXF_I_RXCMD      0
`define UXF_I_TXDONE     1
`define UXF_I_HOST_DISCONNECT_SEEN    2
`define UXF_I_W          3

`endif

// ===== design/uxf_stuff_nrzi.v
/*
 * Line coder: bit-stuffing and NRZI for one serial bit per enable.
 * Assumes the caller presents a bit with bit_en and honours stall_out,
 * during which the stuffed zero is inserted.
 */
`timescale 1ns/100ps
module uxf_stuff_nrzi (
  // Clock and reset.
  input  wire pclk,
  input  wire presetn,
  // Control.
  input  wire restart,
  input  wire raw_mode,
  input  wire bit_en,
  input  wire bit_in,
  // Output.
  output reg  line_q,
  output wire stall_out
);

  reg [2:0] ones_q;
  reg       stuff_pend_q;

  assign stall_out = stuff_pend_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ones_q       <= 3'h0;
      stuff_pend_q <= 1'b0;
      line_q       <= 1'b1;
    end else if (restart) begin
      ones_q       <= 3'h0;
      stuff_pend_q <= 1'b0;
      line_q       <= 1'b1;
    end else if (bit_en) begin
      if (raw_mode) begin
        line_q <= bit_in;
      end else if (stuff_pend_q) begin
        // A stuffed zero toggles the line and resets the run.
        line_q       <= ~line_q;
        ones_q       <= 3'h0;
        stuff_pend_q <= 1'b0;
      end else begin
        line_q       <= bit_in ? line_q : ~line_q;
        ones_q       <= bit_in ? ones_q + 3'h1 : 3'h0;
        stuff_pend_q <= bit_in && (ones_q == 3'h5);
      end
    end
  end

endmodule // uxf_stuff_nrzi

// ===== design/uxf_top.v
/*
 * Status byte assembly and transmit framing of a USB transceiver, with an
 * APB register file and one interrupt line.
 * Assumes line and comparator inputs are synchronous to pclk and that the
 * APB master keeps the standard setup and access phases.
 */
// The implementer's own choices: the APB register port and the register addresses.
// Operation
// - Status bits 1:0 carry minus and plus line levels, plus in bit 0.
// - Status bits 3:2 encode the Vbus level from three comparators.
// - Status bits 5:4 encode receive active, error and host disconnect.
// - Status bit 6 equals the sampled ID pin level.
// - Status bit 7 is set while any non-USB interrupt is latched.
// - Send a status byte on line change when idle and on comparator change.
// - Outgoing packets are bit-stuffed and NRZI coded at every speed.
// - Behaviour decodes speed, mode and both pulldown enables; the termination bit is not decoded.
// - Prepend 32 sync bits at high speed, 8 at full or low speed.
// - Mode code 10 sends chirp data raw, without stuffing or NRZI.
// - A high-speed host appends a 40-bit end of packet after start-of-frame.
// - Start-of-frame is found from PID bits 3:0 of the transmit command.
// - The long end of packet needs both pulldown enables set.
// - In peripheral operation the end of packet is never extended.
// - High-speed disconnect is sampled only during the long end of packet.
`timescale 1ns/100ps
`include "uxf_defines.vh"
module uxf_top #(
  parameter BIT_DIV = 4
) (
  // APB slave.
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Line and comparator inputs.
  input  wire        line_plus,
  input  wire        line_minus,
  input  wire        sess_end,
  input  wire        sess_valid,
  input  wire        vbus_valid,
  input  wire        id_pin,
  input  wire        rx_active,
  input  wire        rx_error,
  input  wire        disconnect_sense,
  input  wire        bus_owned_by_link,
  // Status byte out to the link.
  output reg  [7:0]  rxcmd_q,
  output reg         rxcmd_valid_q,
  // Transmit line and interrupt.
  output wire        tx_line,
  output reg         tx_se0_q,
  output reg         tx_busy_q,
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // States.
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_SYNC = 5'b00010;
  localparam [4:0] S_DATA = 5'b00100;
  localparam [4:0] S_EOP  = 5'b01000;
  localparam [4:0] S_LEOP = 5'b10000;

  reg  [6:0]              ctrl_q;
  reg  [`UXF_I_W-1:0]     istat_q;
  reg  [`UXF_I_W-1:0]     imask_q;
  reg  [7:0]              alt_q;
  reg  [4:0]              st_q;
  reg  [5:0]              cnt_q;
  reg  [7:0]              pid_q;
  reg  [7:0]              sh_q;
  reg  [2:0]              bit_idx_q;
  reg                     pend_q;
  reg                     last_q;
  reg                     host_disconnect_seen_q;
  reg                     long_eop_q;
  reg  [15:0]             div_q;
  reg  [1:0]              ls_q;
  reg  [2:0]              cmp_q;
  reg                     id_q;
  reg  [`UXF_I_W-1:0]     iset;
  wire                    bit_en;
  wire                    stall;
  wire                    wr;
  wire                    rd;
  wire [1:0]              spd;
  wire [1:0]              opm;
  wire                    host_mode;
  wire                    raw_mode;

  // Every access completes in one cycle, so reads are latched in the setup cycle.
  // That keeps prdata steady through the access edge without a wait state.
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign irq     = |(istat_q & imask_q);

  // Speed, mode and pulldowns steer framing below; the termination bit is unused.
  assign spd       = ctrl_q[`UXF_C_SPD_HI:`UXF_C_SPD_LO];
  assign opm       = ctrl_q[`UXF_C_OPM_HI:`UXF_C_OPM_LO];
  assign host_mode = ctrl_q[`UXF_C_DPPD] && ctrl_q[`UXF_C_DMPD];
  assign raw_mode  = (opm == `UXF_OPM_CHIRP);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.
  function [1:0] vbus_code;
    input se;
    input sv;
    input vv;
    begin
      if (vv) begin
        vbus_code = `UXF_VB_ABOVE_VV;
      end else if (sv) begin
        vbus_code = `UXF_VB_BELOW_VV;
      end else if (se) begin
        vbus_code = `UXF_VB_SESS_END;
      end else begin
        vbus_code = `UXF_VB_BELOW_SV;
      end
    end
  endfunction

  function [1:0] event_code;
    input act;
    input err;
    input dis;
    begin
      if (dis) begin
        event_code = `UXF_EV_HOST_DISCONNECT_SEEN;
      end else if (act && err) begin
        event_code = `UXF_EV_ERROR;
      end else if (act) begin
        event_code = `UXF_EV_ACTIVE;
      end else begin
        event_code = `UXF_EV_IDLE;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bit rate enable. High speed runs one bit per clock in this model.
  // The divider runs free, so the first full-speed bit may start up to one period late.
  assign bit_en = (spd == `UXF_SPD_HS) ? 1'b1 : (div_q == 16'h0000);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
    end else if (div_q >= BIT_DIV[15:0] - 16'h0001) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte generation.
  wire       ls_chg  = ({line_minus, line_plus} != ls_q);
  wire       cmp_chg = ({vbus_valid, sess_valid, sess_end} != cmp_q) || (id_pin != id_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_q          <= 2'h0;
      cmp_q         <= 3'h0;
      id_q          <= 1'b0;
      rxcmd_q       <= 8'h00;
      rxcmd_valid_q <= 1'b0;
    end else begin
      ls_q          <= {line_minus, line_plus};
      cmp_q         <= {vbus_valid, sess_valid, sess_end};
      id_q          <= id_pin;
      rxcmd_valid_q <= 1'b0;
      // A disconnect seen in the long end also sends a byte, with event code 10.
      if ((ls_chg && !bus_owned_by_link) || cmp_chg || host_disconnect_seen_q) begin
        rxcmd_valid_q <= 1'b1;
        // Fields are taken from live inputs at the moment of sending.
        rxcmd_q[`UXF_LS_HI:`UXF_LS_LO] <= {line_minus, line_plus};
        rxcmd_q[`UXF_VB_HI:`UXF_VB_LO] <= vbus_code(sess_end, sess_valid, vbus_valid);
        rxcmd_q[`UXF_EV_HI:`UXF_EV_LO] <= event_code(rx_active, rx_error, host_disconnect_seen_q);
        rxcmd_q[`UXF_ID_BIT]           <= id_pin;
        rxcmd_q[`UXF_ALT_BIT]          <= |alt_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit framing.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= S_IDLE;
      cnt_q      <= 6'h00;
      pid_q      <= 8'h00;
      sh_q       <= 8'h00;
      bit_idx_q  <= 3'h0;
      pend_q     <= 1'b0;
      last_q     <= 1'b0;
      long_eop_q <= 1'b0;
      tx_se0_q   <= 1'b0;
      tx_busy_q  <= 1'b0;
      host_disconnect_seen_q  <= 1'b0;
    end else begin
      host_disconnect_seen_q <= 1'b0;
      if (wr && paddr == `UXF_A_TX && st_q == S_IDLE) begin
        pend_q <= 1'b1;
        pid_q  <= pwdata[7:0];
        last_q <= pwdata[8];
      end
      case (st_q)
        S_IDLE: begin
          tx_busy_q <= 1'b0;
          tx_se0_q  <= 1'b0;
          if (pend_q) begin
            pend_q    <= 1'b0;
            st_q      <= S_SYNC;
            tx_busy_q <= 1'b1;
            sh_q      <= pid_q;
            bit_idx_q <= 3'h0;
            // Sync length follows the speed select.
            cnt_q <= (spd == `UXF_SPD_HS) ? `UXF_SYNC_HS : `UXF_SYNC_FSLS;
            // Only a high-speed host extends the end after start-of-frame.
            // Only the PID nibble is decoded, so the command form of the byte works as well.
            long_eop_q <= host_mode && (spd == `UXF_SPD_HS) && !raw_mode &&
                          (pid_q[3:0] == `UXF_PID_SOF);
          end
        end
        S_SYNC: begin
          if (bit_en && !stall) begin
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
              st_q <= S_DATA;
            end
          end
        end
        S_DATA: begin
          if (bit_en && !stall) begin
            sh_q      <= {1'b0, sh_q[7:1]};
            bit_idx_q <= bit_idx_q + 3'h1;
            if (bit_idx_q == 3'h7) begin
              if (long_eop_q) begin
                st_q  <= S_LEOP;
                cnt_q <= `UXF_EOP_LONG;
              end else begin
                st_q  <= S_EOP;
                cnt_q <= (spd == `UXF_SPD_HS) ? `UXF_EOP_HS : `UXF_EOP_FSLS;
              end
            end
          end
        end
        S_EOP, S_LEOP: begin
          // The last data bit stands on the line until the next bit edge, so the
          // single-ended zero starts there and lasts the whole count of bit times.
          if (bit_en) begin
            if (cnt_q == 6'h00) begin
              st_q     <= S_IDLE;
              tx_se0_q <= 1'b0;
            end else begin
              tx_se0_q <= 1'b1;
              cnt_q    <= cnt_q - 6'h01;
              // Disconnect reflections are only looked for in the long end.
              if (st_q == S_LEOP && disconnect_sense) begin
                host_disconnect_seen_q <= 1'b1;
              end
            end
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // Sync bits are zeros that code as alternating line levels, ending in a single one.
  wire tx_bit = (st_q == S_SYNC) ? (cnt_q == 6'h01) : sh_q[0];

  // Stuffing and NRZI unless chirping.
  uxf_stuff_nrzi u_coder (
    .pclk      (pclk),
    .presetn   (presetn),
    .restart   (st_q == S_IDLE),
    .raw_mode  (raw_mode),
    .bit_en    (bit_en && (st_q == S_SYNC || st_q == S_DATA)),
    .bit_in    (tx_bit),
    .line_q    (tx_line),
    .stall_out (stall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupts. A set in the same cycle as a clear wins.
  always @* begin
    iset                 = {`UXF_I_W{1'b0}};
    iset[`UXF_I_RXCMD]   = rxcmd_valid_q;
    iset[`UXF_I_TXDONE]  = tx_busy_q && (st_q == S_IDLE);
    iset[`UXF_I_HOST_DISCONNECT_SEEN] = host_disconnect_seen_q;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 7'h00;
      istat_q <= {`UXF_I_W{1'b0}};
      imask_q <= {`UXF_I_W{1'b0}};
      alt_q   <= 8'h00;
    end else begin
      istat_q <= (istat_q & ~((wr && paddr == `UXF_A_IRQ_STAT) ? pwdata[`UXF_I_W-1:0]
                                                                 : {`UXF_I_W{1'b0}})) | iset;
      if (wr && paddr == `UXF_A_CTRL) begin
        ctrl_q <= pwdata[6:0];
      end
      if (wr && paddr == `UXF_A_IRQ_MASK) begin
        imask_q <= pwdata[`UXF_I_W-1:0];
      end
      // The alternate latch stands in for the non-USB interrupt sources of the status byte.
      // Non-USB sources: software sets by writing, clears with write-one.
      if (wr && paddr == `UXF_A_ALT) begin
        alt_q <= (alt_q & ~pwdata[15:8]) | pwdata[7:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd) begin
      case (paddr)
        `UXF_A_CTRL:     prdata <= {25'h0000000, ctrl_q};
        `UXF_A_STATUS:   prdata <= {18'h00000, st_q, tx_busy_q, rxcmd_q};
        `UXF_A_IRQ_STAT: prdata <= {29'h00000000, istat_q};
        `UXF_A_IRQ_MASK: prdata <= {29'h00000000, imask_q};
        `UXF_A_TX:       prdata <= {23'h000000, last_q, pid_q};
        `UXF_A_ALT:      prdata <= {24'h000000, alt_q};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // uxf_top

// ===== test/uxf_cable_model.sv
/*
 * Cable side of the transmit line: times each packet from its first line change,
 * fakes a disconnect reflection.
 * Assumes tx_busy_q drops between packets.
 */
`timescale 1ns/100ps
module uxf_cable_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        tx_line,
  input  wire        tx_se0_q,
  input  wire        tx_busy_q,
  input  wire        dis_arm,
  output wire        disconnect_sense,
  output logic [6:0] pre_len_q,
  output logic [6:0] eop_len_q,
  output logic       eop_seen_q
);
  logic [6:0] se0_n_q;
  logic [6:0] pre_n_q;
  logic       started_q;
  wire        on_line = started_q || !tx_line;
  // A reflection exists only while the line sits in end of packet, so the pulse lies inside it.
  assign disconnect_sense = dis_arm && tx_se0_q && se0_n_q == 7'h04;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se0_n_q <= 7'h00;
      pre_n_q <= 7'h00;
      started_q <= 1'b0;
      pre_len_q <= 7'h00;
      eop_len_q <= 7'h00;
      eop_seen_q <= 1'b0;
    end else begin
      se0_n_q <= tx_se0_q ? se0_n_q + 7'h01 : 7'h00;
      // Line time counts from the first step off idle, so the free bit divider cannot shift it.
      started_q <= tx_busy_q && on_line;
      pre_n_q <= !tx_busy_q ? 7'h00 : (tx_se0_q || se0_n_q != 7'h00 || !on_line) ? pre_n_q : pre_n_q + 7'h01;
      eop_seen_q <= !tx_se0_q && se0_n_q != 7'h00;
      if (!tx_se0_q && se0_n_q != 7'h00) begin
        pre_len_q <= pre_n_q;
        eop_len_q <= se0_n_q;
      end
    end
  end
endmodule // uxf_cable_model

// ===== test/uxf_top_properties.sv
/*
 * Port checker of uxf_top: status byte content and timing, end of packet length.
 * Assumes the bind below attaches it to every uxf_top.
 */
`timescale 1ns/100ps
module uxf_top_properties #(
  parameter BIT_DIV = 4
) (
  input wire       pclk,
  input wire       presetn,
  input wire       line_plus,
  input wire       line_minus,
  input wire       sess_end,
  input wire       sess_valid,
  input wire       vbus_valid,
  input wire       id_pin,
  input wire       rx_active,
  input wire       rx_error,
  input wire       bus_owned_by_link,
  input wire [7:0] rxcmd_q,
  input wire       rxcmd_valid_q,
  input wire       tx_se0_q,
  input wire       tx_busy_q
);
  logic [6:0] se0_n_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) se0_n_q <= 7'h00;
    else se0_n_q <= tx_se0_q ? se0_n_q + 7'h01 : 7'h00;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_line_chg;
    $past(presetn) && !bus_owned_by_link && {line_minus, line_plus} != $past({line_minus, line_plus});
  endsequence
  sequence s_cmp_chg;
    $past(presetn) && {vbus_valid, sess_valid, sess_end, id_pin} != $past({vbus_valid, sess_valid, sess_end, id_pin});
  endsequence
  property p_line; s_line_chg |=> rxcmd_valid_q; endproperty
  property p_cmp; s_cmp_chg |=> rxcmd_valid_q; endproperty
  property p_ls; rxcmd_valid_q |-> rxcmd_q[1:0] == $past({line_minus, line_plus}); endproperty
  property p_vb;
    rxcmd_valid_q |-> rxcmd_q[3:2] == ($past(vbus_valid) ? 2'h3 : $past(sess_valid) ? 2'h2 : $past(sess_end) ? 2'h0 : 2'h1);
  endproperty
  property p_ev;
    rxcmd_valid_q && !$past(tx_busy_q) |-> rxcmd_q[5:4] == {$past(rx_active & rx_error), $past(rx_active)};
  endproperty
  property p_id; rxcmd_valid_q |-> rxcmd_q[6] == $past(id_pin); endproperty
  property p_dis; rxcmd_valid_q && rxcmd_q[5:4] == 2'h2 |-> $past(tx_se0_q); endproperty
  property p_eop; $fell(tx_se0_q) |-> se0_n_q == 7'h08 || se0_n_q == 7'h28 || se0_n_q == 3 * BIT_DIV; endproperty
  property p_se0; tx_se0_q |-> tx_busy_q; endproperty
  a_line: assert property (p_line) else $error("no byte on line change");
  a_cmp: assert property (p_cmp) else $error("no byte on comparator change");
  a_ls: assert property (p_ls) else $error("line state field wrong");
  a_vb: assert property (p_vb) else $error("vbus field wrong");
  a_ev: assert property (p_ev) else $error("event field wrong");
  a_id: assert property (p_id) else $error("id field wrong");
  a_dis: assert property (p_dis) else $error("disconnect outside end of packet");
  a_eop: assert property (p_eop) else $error("end of packet length wrong");
  a_se0: assert property (p_se0) else $error("end of packet while idle");
endmodule // uxf_top_properties

bind uxf_top uxf_top_properties #(.BIT_DIV(BIT_DIV)) i_uxf_top_properties (
  .pclk(pclk), .presetn(presetn), .line_plus(line_plus), .line_minus(line_minus), .sess_end(sess_end),
  .sess_valid(sess_valid), .vbus_valid(vbus_valid), .id_pin(id_pin), .rx_active(rx_active),
  .rx_error(rx_error), .bus_owned_by_link(bus_owned_by_link), .rxcmd_q(rxcmd_q),
  .rxcmd_valid_q(rxcmd_valid_q), .tx_se0_q(tx_se0_q), .tx_busy_q(tx_busy_q));

// ===== test/uxf_top_tb.sv
/*
 * Self-checking bench of uxf_top with the cable model on its line side.
 * Assumes the design, the checker and the cable model are compiled first.
 */
`timescale 1ns/100ps
`include "uxf_defines.vh"
module uxf_top_tb;
  localparam BIT_DIV = 2;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        owned = 1'b0, dis_arm = 1'b0, alt = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0]  lin = 8'h00;
  wire  [31:0] prdata;
  wire  [7:0]  rxcmd_q;
  wire  [6:0]  pre_len, eop_len;
  wire         pready, pslverr, rxcmd_valid_q, tx_line, tx_se0_q, tx_busy_q, irq, dis, eop_seen;
  int          mismatches = 0, checked = 0;
  logic [7:0]  q_rx[$];
  logic [13:0] q_eop[$];

  always #5 pclk = ~pclk;
  uxf_top #(.BIT_DIV(BIT_DIV)) i_uxf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_plus(lin[0]), .line_minus(lin[1]), .sess_end(lin[2]), .sess_valid(lin[3]), .vbus_valid(lin[4]),
    .id_pin(lin[5]), .rx_active(lin[6]), .rx_error(lin[7]), .disconnect_sense(dis),
    .bus_owned_by_link(owned), .rxcmd_q(rxcmd_q), .rxcmd_valid_q(rxcmd_valid_q), .tx_line(tx_line),
    .tx_se0_q(tx_se0_q), .tx_busy_q(tx_busy_q), .irq(irq));
  uxf_cable_model i_uxf_cable_model (.pclk(pclk), .presetn(presetn), .tx_line(tx_line), .tx_se0_q(tx_se0_q),
    .tx_busy_q(tx_busy_q), .dis_arm(dis_arm), .disconnect_sense(dis), .pre_len_q(pre_len),
    .eop_len_q(eop_len), .eop_seen_q(eop_seen));

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic hang(input string what);
    chk(32'h0, 32'h1, what);
    results;
  endtask
  function automatic logic [1:0] vbf(input logic [7:0] v);
    return v[4] ? 2'h3 : v[3] ? 2'h2 : v[2] ? 2'h0 : 2'h1;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang("no pready");
    rd = prdata;
    chk({31'h0, pslverr}, 32'h0, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Only a change of line pair (while the link does not own the bus), of a comparator or of the ID pin sends a byte.
  task automatic setin(input logic [7:0] v);
    if ((v[1:0] != lin[1:0] && !owned) || v[5:2] != lin[5:2])
      q_rx.push_back({alt, v[5], v[7] & v[6], v[6], vbf(v), v[1:0]});
    lin <= v;
    repeat (4) @(posedge pclk);
  endtask
  task automatic tx(input logic [6:0] ctrl, input logic [7:0] pid, input logic [6:0] pre, input logic [6:0] eop,
                    input logic d);
    int n;
    apb(1'b1, `UXF_A_CTRL, {25'h0, ctrl});
    q_eop.push_back({pre, eop});
    if (d) q_rx.push_back({alt, lin[5], 2'h2, vbf(lin), lin[1:0]});
    dis_arm <= 1'b1;
    apb(1'b1, `UXF_A_TX, {24'h0, pid});
    @(posedge pclk);
    n = 0;
    while (tx_busy_q !== 1'b0 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) hang("transmit stuck");
    repeat (4) @(posedge pclk);
    dis_arm <= 1'b0;
  endtask

  always @(posedge pclk) begin
    if (presetn && rxcmd_valid_q === 1'b1) begin
      if (q_rx.size() == 0) chk({24'h0, rxcmd_q}, 32'h1FF, "stray byte");
      else chk({24'h0, rxcmd_q}, {24'h0, q_rx.pop_front()}, "status byte");
    end
    if (eop_seen === 1'b1) begin
      if (q_eop.size() == 0) chk(32'h0, 32'h1, "stray packet");
      else chk({18'h0, pre_len, eop_len}, {18'h0, q_eop.pop_front()}, "sync and eop");
    end
  end

  initial begin
    void'($urandom(31533));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `UXF_A_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b1, 12'h018, 32'hFFFFFFFF);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0, "unmapped");
    $display("test registers done");
    for (int i = 0; i < 16; i++) setin(8'($urandom));
    owned <= 1'b1;
    @(posedge pclk);
    setin(lin ^ 8'h03);
    owned <= 1'b0;
    apb(1'b1, `UXF_A_ALT, 32'h1);
    alt = 1'b1;
    setin(lin ^ 8'h01);
    apb(1'b1, `UXF_A_ALT, 32'h100);
    alt = 1'b0;
    setin({2'h0, lin[5:0]} ^ 8'h01);
    $display("test status bytes done");
    apb(1'b1, `UXF_A_IRQ_MASK, 32'h4);
    tx(7'h00, 8'hA5, 7'h28, 7'h08, 1'b0);
    tx(7'h60, 8'hE1, 7'h28, 7'h08, 1'b0);
    tx(7'h00, 8'h7E, 7'h29, 7'h08, 1'b0);
    tx(7'h74, 8'h7E, 7'h28, 7'h08, 1'b0);
    tx(7'h05, 8'hA5, 7'(16 * BIT_DIV), 7'(3 * BIT_DIV), 1'b0);
    chk({31'h0, irq}, 32'h0, "irq masked");
    tx(7'h60, 8'hA5, 7'h28, 7'h28, 1'b1);
    tx(7'h60, 8'h45, 7'h28, 7'h28, 1'b1);
    $display("test framing done");
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b0, `UXF_A_IRQ_STAT, 32'h0);
    chk(rd & 32'h6, 32'h6, "irq status");
    apb(1'b1, `UXF_A_IRQ_STAT, 32'h4);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    apb(1'b1, `UXF_A_IRQ_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1, "irq tx done");
    apb(1'b1, `UXF_A_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq unmasked");
    $display("test interrupts done");
    repeat (4) @(posedge pclk);
    results;
  end
endmodule // uxf_top_tb
